// file: rtl/vssr_map.svh
// constants of the voltage setpoint and status block
// assumes inclusion by bare name from the top module and the bench
`ifndef VSSR_MAP_SVH
`define VSSR_MAP_SVH

// ****************************************
// operation register fields
// ****************************************
`define VSSR_OP_CAL_BIT      0
`define VSSR_OP_WTG_BIT      5
`define VSSR_OP_CV_BIT       8
`define VSSR_OP_CC_BIT       10
`define VSSR_OP_USED_MASK    16'h0521
`define VSSR_OP_ENAB_MAX     16'h0521

// ****************************************
// questionable register fields
// ****************************************
`define VSSR_QU_OT_BIT       3
`define VSSR_QU_USED_MASK    16'h0008

// ****************************************
// status byte and error codes
// ****************************************
`define VSSR_ERR_RANGE       16'hFF22
`define VSSR_ERR_COMMAND     16'hFF9C
`define VSSR_ZERO16          16'h0000
`define VSSR_RSP_FIXED       16'h0000
`define VSSR_RSP_LIST        16'h0001
`define VSSR_RSP_VOLTAGE_SETPOINT        16'h0000
`define VSSR_RSP_CURR        16'h0001
`define VSSR_SYNC_STAGES     3

`endif

// file: rtl/vssr_pkg.sv
// types of the voltage setpoint and status block
// assumes the map header sits beside it in rtl/
`default_nettype none

package vssr_pkg;

  typedef enum logic [4:0] {
    VSSR_CMD_NOP        = 5'h00,
    VSSR_CMD_VOLTAGE_SETPOINT_SET   = 5'h01,
    VSSR_CMD_VOLTAGE_SETPOINT_Q     = 5'h02,
    VSSR_CMD_CEIL_SET   = 5'h03,
    VSSR_CMD_CEIL_Q     = 5'h04,
    VSSR_CMD_TRIP_SET   = 5'h05,
    VSSR_CMD_TRIP_Q     = 5'h06,
    VSSR_CMD_PEND_SET   = 5'h07,
    VSSR_CMD_PEND_Q     = 5'h08,
    VSSR_CMD_MODE_SET   = 5'h09,
    VSSR_CMD_MODE_Q     = 5'h0A,
    VSSR_CMD_REG_Q      = 5'h0B,
    VSSR_CMD_OP_LIVE    = 5'h0C,
    VSSR_CMD_OP_MASK    = 5'h0D,
    VSSR_CMD_OP_MASK_Q  = 5'h0E,
    VSSR_CMD_OP_LATCH   = 5'h0F,
    VSSR_CMD_QU_LATCH   = 5'h10,
    VSSR_CMD_QU_LIVE    = 5'h11,
    VSSR_CMD_QU_MASK    = 5'h12,
    VSSR_CMD_QU_MASK_Q  = 5'h13,
    VSSR_CMD_PRESET     = 5'h14,
    VSSR_CMD_INIT       = 5'h15,
    VSSR_CMD_TRIGGER    = 5'h16,
    VSSR_CMD_LIST_EDIT  = 5'h17
  } vssr_cmd_t;

  typedef enum logic [1:0] {
    VSSR_QUAL_NONE = 2'h0,
    VSSR_QUAL_MIN  = 2'h1,
    VSSR_QUAL_MAX  = 2'h2
  } vssr_qual_t;

  typedef enum logic [0:0] {
    VSSR_SEQ_FIXED = 1'b0,
    VSSR_SEQ_LIST  = 1'b1
  } vssr_seq_t;

endpackage

`default_nettype wire

// file: rtl/vssr_top.sv
// voltage setpoint, list-mode control and operation status of a dc source
// assumes a decoded command stream from the host interface on sys_clk;
// regulation and temperature flags arrive as asynchronous pins
//
// Function
// - mode defaults fixed; list selection starts sequence
// - list edits while running give command error
// - fixed during list aborts, restores prior settings
// - completed list leaves final step applied
// - mode query reports list or fixed
// - out-of-range protection value rejected, error -222
// - output above protection level trips breaker
// - protection query: value, factory max, min zero
// - pending trigger voltage above ceiling rejected, -222
// - setpoint above ceiling rejected, -222, old value kept
// - setpoint query: value, rated max, min zero
// - ceiling query returns last accepted ceiling
// - regulation query reports voltage or current
// - condition register is live, not latched
// - bit 10 cc, bit 8 cv, bits 15-11, 9 and 7-6 zero
// - bit 5 awaiting trigger, bits 4-1 zero
// - bit 0 set while computing calibration
// - operation mask takes 0..1313, gates summary
// - status bit 7 ORs masked operation events
// - operation event read returns and clears latch
// - overtemperature latches 8, condition holds 8
// - preset clears both enable masks
// - status bit 3 ORs masked questionable events
// - ceiling above protection level rejected, -222
`timescale 1ns/10ps
`default_nettype none
`include "vssr_map.svh"

module vssr_top
  import vssr_pkg::*;
#(
  parameter logic [15:0] RATED_VOLTAGE = 16'h03E8,
  parameter logic [15:0] TRIP_MAX      = 16'h044C
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        cmd_valid,
  input  wire vssr_cmd_t   cmd_code,
  input  wire vssr_qual_t  cmd_qual,
  input  wire logic [15:0] cmd_value,
  input  wire logic        cc_pin,
  input  wire logic        cv_pin,
  input  wire logic        ot_pin,
  input  wire logic        cal_busy,
  input  wire logic [15:0] vout_meas,
  input  wire logic        list_step_valid,
  input  wire logic [15:0] list_step_voltage_setpoint,
  input  wire logic        list_end,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data,
  output logic             err_valid,
  output logic [15:0]      err_code,
  output logic [15:0]      vout_program,
  output logic             out_enable,
  output logic             breaker_trip,
  output logic             list_running,
  output logic             list_start,
  output logic             stb_oper_sum,
  output logic             stb_ques_sum
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] pin_raw;
  logic [2:0] sync1_reg, sync2_reg, sync3_reg, pin_flt_reg, pin_flt_next;
  assign pin_raw = {ot_pin, cv_pin, cc_pin};

  // a change counts only once stages two and three agree
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_flt_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync2_reg[i] : pin_flt_reg[i];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sync1_reg   <= 3'h0;
      sync2_reg   <= 3'h0;
      sync3_reg   <= 3'h0;
      pin_flt_reg <= 3'h0;
    end else begin
      sync1_reg   <= pin_raw;
      sync2_reg   <= sync1_reg;
      sync3_reg   <= sync2_reg;
      pin_flt_reg <= pin_flt_next;
    end
  end

  // ****************************************
  // live conditions
  // ****************************************
  logic        wtg_reg, wtg_next;
  logic [15:0] op_cond, qu_cond;

  always_comb begin
    op_cond = `VSSR_ZERO16;
    op_cond[`VSSR_OP_CC_BIT]  = pin_flt_reg[0];
    op_cond[`VSSR_OP_CV_BIT]  = pin_flt_reg[1];
    op_cond[`VSSR_OP_WTG_BIT] = wtg_reg;
    op_cond[`VSSR_OP_CAL_BIT] = cal_busy;
    qu_cond = `VSSR_ZERO16;
    qu_cond[`VSSR_QU_OT_BIT]  = pin_flt_reg[2];
  end

  // ****************************************
  // command interpreter and status
  // ****************************************
  logic [15:0] vset_reg, vset_next, ceil_reg, ceil_next, trip_reg, trip_next;
  logic [15:0] pend_reg, pend_next, saved_reg, saved_next, vprog_reg, vprog_next;
  logic [15:0] op_prev_reg, op_prev_next, qu_prev_reg, qu_prev_next;
  logic [15:0] op_evt_reg, op_evt_next, qu_evt_reg, qu_evt_next;
  logic [15:0] op_mask_reg, op_mask_next, qu_mask_reg, qu_mask_next;
  logic [15:0] rsp_data_reg, rsp_data_next, err_code_reg, err_code_next;
  logic        rsp_valid_reg, rsp_valid_next, err_valid_reg, err_valid_next;
  logic        trip_flag_reg, trip_flag_next, start_reg, start_next;
  logic        out_en_reg, out_en_next;
  logic        osum_reg, osum_next, qsum_reg, qsum_next;
  vssr_seq_t   seq_reg, seq_next;
  logic        take;

  assign take = cmd_valid;

  always_comb begin
    vset_next      = vset_reg;
    ceil_next      = ceil_reg;
    trip_next      = trip_reg;
    pend_next      = pend_reg;
    saved_next     = saved_reg;
    vprog_next     = vprog_reg;
    seq_next       = seq_reg;
    wtg_next       = wtg_reg;
    op_mask_next   = op_mask_reg;
    qu_mask_next   = qu_mask_reg;
    rsp_valid_next = 1'b0;
    rsp_data_next  = rsp_data_reg;
    err_valid_next = 1'b0;
    err_code_next  = err_code_reg;
    start_next     = 1'b0;
    op_prev_next   = op_cond;
    qu_prev_next   = qu_cond;
    op_evt_next    = op_evt_reg;
    qu_evt_next    = qu_evt_reg;
    trip_flag_next = trip_flag_reg | (vout_meas > trip_reg);
    out_en_next    = ~trip_flag_next;
    // list steps drive the output, a natural end leaves the last one
    if (seq_reg == VSSR_SEQ_LIST) begin
      if (list_step_valid) begin
        vprog_next = list_step_voltage_setpoint;
      end
      if (list_end) begin
        seq_next = VSSR_SEQ_FIXED;
      end
    end
    if (take) begin
      case (cmd_code)
        VSSR_CMD_VOLTAGE_SETPOINT_SET: begin
          if (cmd_value > ceil_reg) begin
            err_valid_next = 1'b1;
            err_code_next  = `VSSR_ERR_RANGE;
          end else begin
            vset_next  = cmd_value;
            vprog_next = cmd_value;
          end
        end
        VSSR_CMD_VOLTAGE_SETPOINT_Q: begin
          rsp_valid_next = 1'b1;
          rsp_data_next  = (cmd_qual == VSSR_QUAL_MAX) ? RATED_VOLTAGE :
                           (cmd_qual == VSSR_QUAL_MIN) ? `VSSR_ZERO16 : vset_reg;
        end
        VSSR_CMD_CEIL_SET: begin
          if (cmd_value > trip_reg) begin
            err_valid_next = 1'b1;
            err_code_next  = `VSSR_ERR_RANGE;
          end else begin
            ceil_next = cmd_value;
          end
        end
        VSSR_CMD_CEIL_Q: begin
          rsp_valid_next = 1'b1;
          rsp_data_next  = ceil_reg;
        end
        VSSR_CMD_TRIP_SET: begin
          if (cmd_value > TRIP_MAX) begin
            err_valid_next = 1'b1;
            err_code_next  = `VSSR_ERR_RANGE;
          end else begin
            trip_next = cmd_value;
          end
        end
        VSSR_CMD_TRIP_Q: begin
          rsp_valid_next = 1'b1;
          rsp_data_next  = (cmd_qual == VSSR_QUAL_MAX) ? TRIP_MAX :
                           (cmd_qual == VSSR_QUAL_MIN) ? `VSSR_ZERO16 : trip_reg;
        end
        VSSR_CMD_PEND_SET: begin
          if (cmd_value > ceil_reg) begin
            err_valid_next = 1'b1;
            err_code_next  = `VSSR_ERR_RANGE;
          end else begin
            pend_next = cmd_value;
          end
        end
        VSSR_CMD_PEND_Q: begin
          rsp_valid_next = 1'b1;
          rsp_data_next  = pend_reg;
        end
        VSSR_CMD_MODE_SET: begin
          if (cmd_value[0] && seq_reg == VSSR_SEQ_FIXED) begin
            seq_next   = VSSR_SEQ_LIST;
            saved_next = vprog_reg;
            start_next = 1'b1;
          end else if (!cmd_value[0] && seq_reg == VSSR_SEQ_LIST) begin
            seq_next   = VSSR_SEQ_FIXED;
            vprog_next = saved_reg;
          end
        end
        VSSR_CMD_MODE_Q: begin
          rsp_valid_next = 1'b1;
          rsp_data_next  = (seq_reg == VSSR_SEQ_LIST) ? `VSSR_RSP_LIST : `VSSR_RSP_FIXED;
        end
        VSSR_CMD_REG_Q: begin
          rsp_valid_next = 1'b1;
          rsp_data_next  = pin_flt_reg[0] ? `VSSR_RSP_CURR : `VSSR_RSP_VOLTAGE_SETPOINT;
        end
        VSSR_CMD_OP_LIVE: begin
          rsp_valid_next = 1'b1;
          rsp_data_next  = op_cond;
        end
        VSSR_CMD_OP_MASK: begin
          if (cmd_value > `VSSR_OP_ENAB_MAX) begin
            err_valid_next = 1'b1;
            err_code_next  = `VSSR_ERR_RANGE;
          end else begin
            op_mask_next = cmd_value & `VSSR_OP_USED_MASK;
          end
        end
        VSSR_CMD_OP_MASK_Q: begin
          rsp_valid_next = 1'b1;
          rsp_data_next  = op_mask_reg;
        end
        VSSR_CMD_OP_LATCH: begin
          rsp_valid_next = 1'b1;
          rsp_data_next  = op_evt_reg;
          op_evt_next    = `VSSR_ZERO16;
        end
        VSSR_CMD_QU_LATCH: begin
          rsp_valid_next = 1'b1;
          rsp_data_next  = qu_evt_reg;
          qu_evt_next    = `VSSR_ZERO16;
        end
        VSSR_CMD_QU_LIVE: begin
          rsp_valid_next = 1'b1;
          rsp_data_next  = qu_cond;
        end
        VSSR_CMD_QU_MASK: begin
          qu_mask_next = cmd_value & `VSSR_QU_USED_MASK;
        end
        VSSR_CMD_QU_MASK_Q: begin
          rsp_valid_next = 1'b1;
          rsp_data_next  = qu_mask_reg;
        end
        VSSR_CMD_PRESET: begin
          op_mask_next = `VSSR_ZERO16;
          qu_mask_next = `VSSR_ZERO16;
        end
        VSSR_CMD_INIT: begin
          wtg_next = 1'b1;
        end
        VSSR_CMD_TRIGGER: begin
          if (wtg_reg) begin
            wtg_next   = 1'b0;
            vset_next  = pend_reg;
            vprog_next = pend_reg;
          end
        end
        VSSR_CMD_LIST_EDIT: begin
          if (seq_reg == VSSR_SEQ_LIST) begin
            err_valid_next = 1'b1;
            err_code_next  = `VSSR_ERR_COMMAND;
          end
        end
        default: begin
          err_valid_next = 1'b1;
          err_code_next  = `VSSR_ERR_COMMAND;
        end
      endcase
    end
    // new edges set after a read clears, so a same-cycle event survives
    op_evt_next = op_evt_next | (op_cond & ~op_prev_reg);
    qu_evt_next = qu_evt_next | (qu_cond & ~qu_prev_reg);
    osum_next   = |(op_evt_next & op_mask_next);
    qsum_next   = |(qu_evt_next & qu_mask_next);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      vset_reg      <= `VSSR_ZERO16;
      ceil_reg      <= RATED_VOLTAGE;
      trip_reg      <= TRIP_MAX;
      pend_reg      <= `VSSR_ZERO16;
      saved_reg     <= `VSSR_ZERO16;
      vprog_reg     <= `VSSR_ZERO16;
      seq_reg       <= VSSR_SEQ_FIXED;
      wtg_reg       <= 1'b0;
      op_mask_reg   <= `VSSR_ZERO16;
      qu_mask_reg   <= `VSSR_ZERO16;
      op_prev_reg   <= `VSSR_ZERO16;
      qu_prev_reg   <= `VSSR_ZERO16;
      op_evt_reg    <= `VSSR_ZERO16;
      qu_evt_reg    <= `VSSR_ZERO16;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= `VSSR_ZERO16;
      err_valid_reg <= 1'b0;
      err_code_reg  <= `VSSR_ZERO16;
      trip_flag_reg <= 1'b0;
      out_en_reg    <= 1'b1;
      start_reg     <= 1'b0;
      osum_reg      <= 1'b0;
      qsum_reg      <= 1'b0;
    end else begin
      vset_reg      <= vset_next;
      ceil_reg      <= ceil_next;
      trip_reg      <= trip_next;
      pend_reg      <= pend_next;
      saved_reg     <= saved_next;
      vprog_reg     <= vprog_next;
      seq_reg       <= seq_next;
      wtg_reg       <= wtg_next;
      op_mask_reg   <= op_mask_next;
      qu_mask_reg   <= qu_mask_next;
      op_prev_reg   <= op_prev_next;
      qu_prev_reg   <= qu_prev_next;
      op_evt_reg    <= op_evt_next;
      qu_evt_reg    <= qu_evt_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg  <= rsp_data_next;
      err_valid_reg <= err_valid_next;
      err_code_reg  <= err_code_next;
      trip_flag_reg <= trip_flag_next;
      out_en_reg    <= out_en_next;
      start_reg     <= start_next;
      osum_reg      <= osum_next;
      qsum_reg      <= qsum_next;
    end
  end

  assign rsp_valid    = rsp_valid_reg;
  assign rsp_data     = rsp_data_reg;
  assign err_valid    = err_valid_reg;
  assign err_code     = err_code_reg;
  // breaker holds the output off until reset
  assign vout_program = vprog_reg;
  assign out_enable   = out_en_reg;
  assign breaker_trip = trip_flag_reg;
  assign list_running = (seq_reg == VSSR_SEQ_LIST);
  assign list_start   = start_reg;
  assign stb_oper_sum = osum_reg;
  assign stb_ques_sum = qsum_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_voltage_setpoint_range_err: assert property (take && cmd_code == VSSR_CMD_VOLTAGE_SETPOINT_SET && cmd_value > ceil_reg
    |=> err_valid && err_code == `VSSR_ERR_RANGE && $stable(vset_reg))
    else $error("over-ceiling setpoint not rejected");
  a_trip_range_err: assert property (take && cmd_code == VSSR_CMD_TRIP_SET && cmd_value > TRIP_MAX
    |=> err_valid && err_code == `VSSR_ERR_RANGE)
    else $error("protection level range error missing");
  a_ceil_over_trip: assert property (take && cmd_code == VSSR_CMD_CEIL_SET && cmd_value > trip_reg
    |=> err_valid && $stable(ceil_reg))
    else $error("ceiling above protection accepted");
  a_list_edit_err: assert property (take && cmd_code == VSSR_CMD_LIST_EDIT && list_running
    |=> err_valid && err_code == `VSSR_ERR_COMMAND)
    else $error("list edit during run not refused");
  a_abort_restore: assert property (take && cmd_code == VSSR_CMD_MODE_SET && !cmd_value[0]
    && list_running |=> !list_running && vout_program == $past(saved_reg))
    else $error("abort did not restore settings");
  a_breaker_trip: assert property (vout_meas > trip_reg |=> breaker_trip && !out_enable)
    else $error("breaker did not trip");
  a_evt_read_clear: assert property (take && cmd_code == VSSR_CMD_OP_LATCH && op_cond == op_prev_reg
    |=> rsp_data == $past(op_evt_reg) && op_evt_reg == `VSSR_ZERO16)
    else $error("event read did not clear");
  a_oper_summary: assert property (stb_oper_sum == |(op_evt_reg & op_mask_reg))
    else $error("operation summary wrong");
  a_preset_masks: assert property (take && cmd_code == VSSR_CMD_PRESET
    |=> op_mask_reg == `VSSR_ZERO16 && qu_mask_reg == `VSSR_ZERO16)
    else $error("preset left a mask set");
  a_mode_query: assert property (take && cmd_code == VSSR_CMD_MODE_Q
    |=> rsp_valid && rsp_data[0] == $past(list_running))
    else $error("mode query wrong");

  c_list_complete: cover property (list_start ##[1:20] (list_running && list_end));
  c_oper_event:    cover property (stb_oper_sum);
  c_ot_latch:      cover property (qu_evt_reg[`VSSR_QU_OT_BIT] ##1 stb_ques_sum);

endmodule

`default_nettype wire

// file: dv/vssr_host_model.sv
// host side model: issues one decoded command at a time, collects the answer
// assumes the block answers within two cycles of the taking edge
`timescale 1ns/10ps
`default_nettype none

module vssr_host_model
  import vssr_pkg::*;
(
  input  wire logic        sys_clk,
  output var  logic        cmd_valid,
  output var  vssr_cmd_t   cmd_code,
  output var  vssr_qual_t  cmd_qual,
  output var  logic [15:0] cmd_value,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data,
  input  wire logic        err_valid,
  input  wire logic [15:0] err_code
);

  initial begin
    cmd_valid = 1'b0;
    cmd_code  = VSSR_CMD_NOP;
    cmd_qual  = VSSR_QUAL_NONE;
    cmd_value = 16'h0000;
  end

  // ****************************************
  // one command, answer window of two cycles
  // ****************************************
  task automatic xfer(input vssr_cmd_t c, input vssr_qual_t q, input logic [15:0] v,
                      output logic got_rsp, output logic [15:0] data,
                      output logic got_err, output logic [15:0] code);
    got_rsp = 1'b0;
    got_err = 1'b0;
    data = 16'h0000;
    code = 16'h0000;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_code  = c;
    cmd_qual  = q;
    cmd_value = v;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    cmd_code  = VSSR_CMD_NOP;
    // stale argument must not pass for a held one
    cmd_value = ~v;
    for (int i = 0; i < 2; i++) begin
      if (rsp_valid === 1'b1) begin
        got_rsp = 1'b1;
        data = rsp_data;
      end
      if (err_valid === 1'b1) begin
        got_err = 1'b1;
        code = err_code;
      end
      @(negedge sys_clk);
    end
  endtask

endmodule

`default_nettype wire

// file: dv/vssr_top_tb_top.sv
// self-checking bench of the voltage setpoint and status block
// assumes the host model beside it and the map header in rtl/
`timescale 1ns/10ps
`default_nettype none
`include "vssr_map.svh"

module vssr_top_tb_top;
  import vssr_pkg::*;

  localparam logic [15:0] RATED = 16'h03E8;
  localparam logic [15:0] TRIPM = 16'h044C;

  logic        sys_clk, srst, cmd_valid, cc_pin, cv_pin, ot_pin, cal_busy;
  logic        list_step_valid, list_end, rsp_valid, err_valid, out_enable;
  logic        breaker_trip, list_running, list_start, stb_oper_sum, stb_ques_sum;
  logic [15:0] cmd_value, vout_meas, list_step_voltage_setpoint, rsp_data, err_code, vout_program;
  vssr_cmd_t   cmd_code;
  vssr_qual_t  cmd_qual;
  logic        gr, ge;
  logic [15:0] gd, gc;
  int          err_total = 0;
  int          samples_checked = 0;
  int          starts = 0;

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  vssr_top #(.RATED_VOLTAGE(RATED), .TRIP_MAX(TRIPM)) uut (
    .sys_clk(sys_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_qual(cmd_qual), .cmd_value(cmd_value), .cc_pin(cc_pin), .cv_pin(cv_pin),
    .ot_pin(ot_pin), .cal_busy(cal_busy), .vout_meas(vout_meas),
    .list_step_valid(list_step_valid), .list_step_voltage_setpoint(list_step_voltage_setpoint),
    .list_end(list_end), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .err_valid(err_valid), .err_code(err_code), .vout_program(vout_program),
    .out_enable(out_enable), .breaker_trip(breaker_trip), .list_running(list_running),
    .list_start(list_start), .stb_oper_sum(stb_oper_sum), .stb_ques_sum(stb_ques_sum)
  );

  vssr_host_model host (
    .sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_qual(cmd_qual),
    .cmd_value(cmd_value), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .err_valid(err_valid), .err_code(err_code)
  );

  always @(posedge sys_clk) begin
    if (list_start === 1'b1) begin
      starts <= starts + 1;
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic put(input vssr_cmd_t c, input logic [15:0] v);
    host.xfer(c, VSSR_QUAL_NONE, v, gr, gd, ge, gc);
    chk({15'h0000, ge}, 16'h0000);
  endtask

  task automatic ask(input vssr_cmd_t c, input vssr_qual_t q, input logic [15:0] exp);
    host.xfer(c, q, 16'h0000, gr, gd, ge, gc);
    chk({15'h0000, gr}, 16'h0001);
    chk(gd, exp);
  endtask

  task automatic bad(input vssr_cmd_t c, input logic [15:0] v, input logic [15:0] code);
    host.xfer(c, VSSR_QUAL_NONE, v, gr, gd, ge, gc);
    chk({15'h0000, ge}, 16'h0001);
    chk(gc, code);
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic step(input logic [15:0] v);
    @(negedge sys_clk);
    list_step_voltage_setpoint = v;
    list_step_valid = 1'b1;
    @(negedge sys_clk);
    list_step_valid = 1'b0;
    list_step_voltage_setpoint = ~v;
    wt(1);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    srst = 1'b1;
    {cc_pin, cv_pin, ot_pin, cal_busy, list_step_valid, list_end} = 6'h00;
    vout_meas = 16'h0000;
    list_step_voltage_setpoint = 16'h0000;
    wt(5);
    srst = 1'b0;
    chk(vout_program, 16'h0000);
    chk({15'h0000, out_enable}, 16'h0001);
    chk({15'h0000, list_running}, 16'h0000);
    ask(VSSR_CMD_MODE_Q, VSSR_QUAL_NONE, `VSSR_RSP_FIXED);
    ask(VSSR_CMD_CEIL_Q, VSSR_QUAL_NONE, RATED);
    ask(VSSR_CMD_TRIP_Q, VSSR_QUAL_NONE, TRIPM);
    ask(VSSR_CMD_TRIP_Q, VSSR_QUAL_MAX, TRIPM);
    ask(VSSR_CMD_TRIP_Q, VSSR_QUAL_MIN, 16'h0000);
    ask(VSSR_CMD_VOLTAGE_SETPOINT_Q, VSSR_QUAL_MAX, RATED);
    ask(VSSR_CMD_VOLTAGE_SETPOINT_Q, VSSR_QUAL_MIN, 16'h0000);
    $display("test reset done");

    put(VSSR_CMD_VOLTAGE_SETPOINT_SET, 16'h0200);
    chk(vout_program, 16'h0200);
    put(VSSR_CMD_CEIL_SET, 16'h0300);
    ask(VSSR_CMD_CEIL_Q, VSSR_QUAL_NONE, 16'h0300);
    bad(VSSR_CMD_VOLTAGE_SETPOINT_SET, 16'h0301, `VSSR_ERR_RANGE);
    ask(VSSR_CMD_VOLTAGE_SETPOINT_Q, VSSR_QUAL_NONE, 16'h0200);
    chk(vout_program, 16'h0200);
    bad(VSSR_CMD_CEIL_SET, TRIPM + 16'h0001, `VSSR_ERR_RANGE);
    ask(VSSR_CMD_CEIL_Q, VSSR_QUAL_NONE, 16'h0300);
    bad(VSSR_CMD_TRIP_SET, TRIPM + 16'h0001, `VSSR_ERR_RANGE);
    ask(VSSR_CMD_TRIP_Q, VSSR_QUAL_NONE, TRIPM);
    put(VSSR_CMD_TRIP_SET, 16'h0400);
    ask(VSSR_CMD_TRIP_Q, VSSR_QUAL_NONE, 16'h0400);
    bad(VSSR_CMD_PEND_SET, 16'h0301, `VSSR_ERR_RANGE);
    put(VSSR_CMD_PEND_SET, 16'h0250);
    ask(VSSR_CMD_PEND_Q, VSSR_QUAL_NONE, 16'h0250);
    put(VSSR_CMD_INIT, 16'h0000);
    ask(VSSR_CMD_OP_LIVE, VSSR_QUAL_NONE, 16'h0020);
    put(VSSR_CMD_TRIGGER, 16'h0000);
    chk(vout_program, 16'h0250);
    ask(VSSR_CMD_OP_LIVE, VSSR_QUAL_NONE, 16'h0000);
    $display("test setpoint done");

    ask(VSSR_CMD_OP_LATCH, VSSR_QUAL_NONE, 16'h0020);
    ask(VSSR_CMD_OP_LATCH, VSSR_QUAL_NONE, 16'h0000);
    cal_busy = 1'b1;
    cc_pin = 1'b1;
    // pins need four edges through the synchronisers
    wt(6);
    ask(VSSR_CMD_OP_LIVE, VSSR_QUAL_NONE, 16'h0401);
    ask(VSSR_CMD_REG_Q, VSSR_QUAL_NONE, `VSSR_RSP_CURR);
    cc_pin = 1'b0;
    cv_pin = 1'b1;
    cal_busy = 1'b0;
    wt(6);
    ask(VSSR_CMD_OP_LIVE, VSSR_QUAL_NONE, 16'h0100);
    ask(VSSR_CMD_REG_Q, VSSR_QUAL_NONE, `VSSR_RSP_VOLTAGE_SETPOINT);
    bad(VSSR_CMD_OP_MASK, 16'h0522, `VSSR_ERR_RANGE);
    put(VSSR_CMD_OP_MASK, 16'h0020);
    chk({15'h0000, stb_oper_sum}, 16'h0000);
    put(VSSR_CMD_OP_MASK, `VSSR_OP_ENAB_MAX);
    chk({15'h0000, stb_oper_sum}, 16'h0001);
    ask(VSSR_CMD_OP_MASK_Q, VSSR_QUAL_NONE, 16'h0521);
    ask(VSSR_CMD_OP_LATCH, VSSR_QUAL_NONE, 16'h0501);
    chk({15'h0000, stb_oper_sum}, 16'h0000);
    ask(VSSR_CMD_OP_LATCH, VSSR_QUAL_NONE, 16'h0000);
    $display("test operation status done");

    put(VSSR_CMD_QU_MASK, 16'h0008);
    ot_pin = 1'b1;
    wt(6);
    chk({15'h0000, stb_ques_sum}, 16'h0001);
    ask(VSSR_CMD_QU_LATCH, VSSR_QUAL_NONE, 16'h0008);
    ask(VSSR_CMD_QU_LIVE, VSSR_QUAL_NONE, 16'h0008);
    ask(VSSR_CMD_QU_LATCH, VSSR_QUAL_NONE, 16'h0000);
    chk({15'h0000, stb_ques_sum}, 16'h0000);
    put(VSSR_CMD_PRESET, 16'h0000);
    ask(VSSR_CMD_OP_MASK_Q, VSSR_QUAL_NONE, 16'h0000);
    ask(VSSR_CMD_QU_MASK_Q, VSSR_QUAL_NONE, 16'h0000);
    ot_pin = 1'b0;
    wt(6);
    ot_pin = 1'b1;
    wt(6);
    chk({15'h0000, stb_ques_sum}, 16'h0000);
    ask(VSSR_CMD_QU_LATCH, VSSR_QUAL_NONE, 16'h0008);
    $display("test questionable done");

    put(VSSR_CMD_VOLTAGE_SETPOINT_SET, 16'h0100);
    put(VSSR_CMD_MODE_SET, 16'h0001);
    chk({15'h0000, list_running}, 16'h0001);
    chk(starts[15:0], 16'h0001);
    ask(VSSR_CMD_MODE_Q, VSSR_QUAL_NONE, `VSSR_RSP_LIST);
    bad(VSSR_CMD_LIST_EDIT, 16'h0000, `VSSR_ERR_COMMAND);
    step(16'h0180);
    chk(vout_program, 16'h0180);
    put(VSSR_CMD_MODE_SET, 16'h0000);
    chk({15'h0000, list_running}, 16'h0000);
    chk(vout_program, 16'h0100);
    ask(VSSR_CMD_MODE_Q, VSSR_QUAL_NONE, `VSSR_RSP_FIXED);
    put(VSSR_CMD_MODE_SET, 16'h0001);
    chk(starts[15:0], 16'h0002);
    step(16'h0190);
    list_end = 1'b1;
    wt(1);
    list_end = 1'b0;
    wt(2);
    chk({15'h0000, list_running}, 16'h0000);
    chk(vout_program, 16'h0190);
    $display("test list done");

    // equal to the trip level is not above it
    vout_meas = 16'h0400;
    wt(4);
    chk({15'h0000, breaker_trip}, 16'h0000);
    vout_meas = 16'h0401;
    wt(4);
    chk({15'h0000, breaker_trip}, 16'h0001);
    chk({15'h0000, out_enable}, 16'h0000);
    // breaker only clears through reset
    srst = 1'b1;
    wt(2);
    srst = 1'b0;
    chk({15'h0000, breaker_trip}, 16'h0000);
    chk({15'h0000, out_enable}, 16'h0001);
    ask(VSSR_CMD_CEIL_Q, VSSR_QUAL_NONE, RATED);
    ask(VSSR_CMD_MODE_Q, VSSR_QUAL_NONE, `VSSR_RSP_FIXED);
    $display("test breaker done");
    report_and_stop();
  end

  // about eleven times the expected run length
  initial begin
    repeat (3000) @(posedge sys_clk);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end

endmodule

`default_nettype wire
